// ---- hw/crfs_pkg.sv ----
package crfs_pkg;
   localparam int CRFS_SLOTS = 16;
   localparam int CRFS_AW = 12;
   localparam int CRFS_ID_W = 29;
   localparam int CRFS_TS_W = 16;
   // Register map
   localparam logic [11:0] CRFS_OFS_ID_MASK = 12'h000;
   localparam logic [11:0] CRFS_OFS_MODE = 12'h004;
   localparam logic [11:0] CRFS_OFS_IRQ_STAT = 12'h008;
   localparam logic [11:0] CRFS_OFS_IRQ_EN = 12'h00C;
   localparam logic [3:0] CRFS_SLOT_PAGE = 4'h1;
   localparam logic [3:0] CRFS_SLOT_CTRL = 4'h0;
   localparam logic [3:0] CRFS_SLOT_ID = 4'h4;
   localparam logic [3:0] CRFS_SLOT_FMT = 4'h8;
   localparam logic [3:0] CRFS_SLOT_TSP = 4'hC;
   localparam int CRFS_FMT_EXT_BIT = 8;
   localparam int CRFS_MODE_BASIC_BIT = 0;
   // Mode nibble of slot_control, bits 7..4
   localparam int CRFS_MB_SEND = 3;
   localparam int CRFS_MB_RCV = 2;
   localparam int CRFS_MB_REM = 1;
   localparam int CRFS_MB_NOREPLY = 0;
   // Status bits of slot_control
   localparam int CRFS_CB_RACT = 3;
   localparam int CRFS_CB_LOST = 2;
   localparam int CRFS_CB_BUSY = 1;
   localparam int CRFS_CB_DONE = 0;
   // Commands written to slot_control
   localparam logic [7:0] CRFS_CMD_STOP = 8'h00;
   localparam logic [7:0] CRFS_CMD_CANCEL = 8'h0F;
   localparam logic [7:0] CRFS_CMD_RXDATA = 8'hAE;
   localparam logic [7:0] CRFS_CMD_RETX = 8'hA0;
   localparam logic [7:0] CRFS_CMD_REM_AUTO = 8'h60;
   localparam logic [7:0] CRFS_CMD_REM_NOAUTO = 8'h70;
   localparam int CRFS_BASIC_FIRST = 14;
   // Reset values
   localparam logic [28:0] CRFS_RST_MASK = 29'h1FFF_FFFF;
   localparam logic [15:0] CRFS_RST_IRQ_EN = 16'h0000;
   typedef enum logic [1:0] {
      CRFS_ST_IDLE = 2'b00,
      CRFS_ST_STORE = 2'b01,
      CRFS_ST_FIN = 2'b11
   } crfs_state_e;
endpackage

// ---- hw/crfs_slots.sv ----
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module crfs_slots
   import crfs_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [CRFS_AW-1:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Received frame from the protocol engine
   input wire logic i_rx_valid,
   input wire logic i_rx_rtr,
   input wire logic i_rx_ext,
   input wire logic [CRFS_ID_W-1:0] i_rx_id,
   input wire logic [3:0] i_rx_dlc,
   // Transmit request to the protocol engine
   input wire logic i_intermission,
   output logic o_tx_valid,
   output logic [3:0] o_tx_slot,
   output logic o_tx_rtr,
   output logic o_tx_ext,
   output logic [CRFS_ID_W-1:0] o_tx_id,
   output logic [3:0] o_tx_dlc,
   input wire logic i_tx_done,
   input wire logic i_tx_fail,
   // Slot interrupt status
   output logic [CRFS_SLOTS-1:0] o_slot_irq_status,
   output logic o_irq_req
);
   function automatic logic [3:0] crfs_first(input logic [CRFS_SLOTS-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int k = CRFS_SLOTS - 1; k >= 0; k--)
      begin
         if (v[k])
            r = 4'(k);
      end
      return r;
   endfunction

   // Per-slot state
   logic [3:0] mode_q [CRFS_SLOTS];
   logic ract_q [CRFS_SLOTS];
   logic lost_q [CRFS_SLOTS];
   logic busy_q [CRFS_SLOTS];
   logic done_q [CRFS_SLOTS];
   logic rxdata_q [CRFS_SLOTS];
   logic arp_q [CRFS_SLOTS];
   logic abort_q [CRFS_SLOTS];
   logic [CRFS_ID_W-1:0] id_q [CRFS_SLOTS];
   logic ext_q [CRFS_SLOTS];
   logic [3:0] dlc_q [CRFS_SLOTS];
   logic [CRFS_TS_W-1:0] tsp_q [CRFS_SLOTS];
   wire [CRFS_SLOTS-1:0] match_w;
   wire [CRFS_SLOTS-1:0] pend_w;
   wire [CRFS_SLOTS-1:0] irq_set_w;

   // Global state
   crfs_state_e st_q, st_d;
   logic [3:0] sel_q, sel_d;
   logic fr_rtr_q, fr_rtr_d;
   logic fr_ext_q, fr_ext_d;
   logic [CRFS_ID_W-1:0] fr_id_q, fr_id_d;
   logic [3:0] fr_dlc_q, fr_dlc_d;
   logic tx_act_q, tx_act_d;
   logic [3:0] tx_slot_q, tx_slot_d;
   logic tx_rtr_q, tx_rtr_d;
   logic tx_ext_q, tx_ext_d;
   logic [CRFS_ID_W-1:0] tx_id_q, tx_id_d;
   logic [3:0] tx_dlc_q, tx_dlc_d;
   logic [CRFS_TS_W-1:0] ts_q, ts_d;
   logic [CRFS_ID_W-1:0] mask_q, mask_d;
   logic basic_q, basic_d;
   logic [CRFS_SLOTS-1:0] istat_q, istat_d;
   logic [CRFS_SLOTS-1:0] ien_q, ien_d;
   logic [31:0] rdata_q, rdata_d;
   logic tx_start;
   logic [3:0] tx_pick;
   logic slot_page;

   assign slot_page = (i_reg_addr[11:8] == CRFS_SLOT_PAGE);
   assign tx_pick = crfs_first(pend_w);
   assign tx_start = i_intermission && !tx_act_q && (|pend_w);

   genvar g;
   generate
      for (g = 0; g < CRFS_SLOTS; g++)
      begin : gen_slot
         logic [3:0] mode_d;
         logic ract_d, lost_d, busy_d, done_d, rxdata_d, arp_d, abort_d, ext_d;
         logic [CRFS_ID_W-1:0] id_d;
         logic [3:0] dlc_d;
         logic [CRFS_TS_W-1:0] tsp_d;
         logic here, wr_ctrl, tx_mine, auto_ok;
         logic [7:0] w;

         assign here = slot_page && (i_reg_addr[7:4] == 4'(g));
         assign wr_ctrl = i_reg_wr && here && (i_reg_addr[3:0] == CRFS_SLOT_CTRL);
         assign w = i_reg_wdata[7:0];
         assign tx_mine = tx_act_q && (tx_slot_q == 4'(g));
         assign auto_ok = !mode_q[g][CRFS_MB_NOREPLY]
            && !(basic_q && g >= CRFS_BASIC_FIRST);
         assign match_w[g] = ((i_rx_rtr && mode_q[g][CRFS_MB_RCV] && mode_q[g][CRFS_MB_REM]
               && ract_q[g] && !arp_q[g] && !busy_q[g])
            || (!i_rx_rtr && mode_q[g][CRFS_MB_SEND] && mode_q[g][CRFS_MB_REM]
               && rxdata_q[g]))
            && (((i_rx_id ^ id_q[g]) & mask_q) == '0) && (i_rx_ext == ext_q[g]);
         assign pend_w[g] = !busy_q[g] && !abort_q[g] && !(basic_q && g >= CRFS_BASIC_FIRST)
            && ((mode_q[g][CRFS_MB_SEND] && mode_q[g][CRFS_MB_REM] && ract_q[g]
               && !rxdata_q[g]) || arp_q[g]);
         assign irq_set_w[g] = (st_q == CRFS_ST_FIN && sel_q == 4'(g))
            || (tx_mine && i_tx_done);

         always_comb
         begin
            mode_d = mode_q[g];
            ract_d = ract_q[g];
            lost_d = lost_q[g];
            busy_d = busy_q[g];
            done_d = done_q[g];
            rxdata_d = rxdata_q[g];
            arp_d = arp_q[g];
            abort_d = abort_q[g];
            id_d = id_q[g];
            ext_d = ext_q[g];
            dlc_d = dlc_q[g];
            tsp_d = tsp_q[g];
            // Hardware sets below win over software
            if (i_reg_wr && here && i_reg_addr[3:0] == CRFS_SLOT_ID)
               id_d = i_reg_wdata[CRFS_ID_W-1:0];
            if (i_reg_wr && here && i_reg_addr[3:0] == CRFS_SLOT_FMT)
            begin
               dlc_d = i_reg_wdata[3:0];
               ext_d = i_reg_wdata[CRFS_FMT_EXT_BIT];
            end
            if (wr_ctrl)
            begin
               if (w == CRFS_CMD_RXDATA && mode_q[g][CRFS_MB_SEND] && mode_q[g][CRFS_MB_REM])
               begin
                  done_d = 1'b0;
                  rxdata_d = 1'b1;
               end
               else if (w == CRFS_CMD_RETX)
               begin
                  mode_d = w[7:4];
                  done_d = 1'b0;
                  rxdata_d = 1'b0;
                  ract_d = 1'b1;
               end
               else if (w == CRFS_CMD_REM_AUTO || w == CRFS_CMD_REM_NOAUTO)
               begin
                  mode_d = w[7:4];
                  ract_d = 1'b1;
                  rxdata_d = 1'b0;
                  arp_d = 1'b0;
               end
               else if (w[7:4] == CRFS_CMD_STOP[7:4])
               begin
                  done_d = 1'b0;
                  lost_d = 1'b0;
                  // A slot on the wire waits for the engine
                  if (tx_mine)
                     abort_d = 1'b1;
                  else
                  begin
                     mode_d = 4'h0;
                     ract_d = 1'b0;
                     rxdata_d = 1'b0;
                     arp_d = 1'b0;
                  end
               end
               else
               begin
                  mode_d = w[7:4];
                  if (!w[CRFS_CB_DONE])
                     done_d = 1'b0;
                  if (!w[CRFS_CB_LOST])
                     lost_d = 1'b0;
               end
            end
            if (st_q == CRFS_ST_STORE && sel_q == 4'(g))
            begin
               busy_d = 1'b1;
               if (!fr_rtr_q && done_q[g])
                  lost_d = 1'b1;
               done_d = 1'b1;
               id_d = fr_id_q;
               ext_d = fr_ext_q;
               dlc_d = fr_dlc_q;
               tsp_d = ts_q;
            end
            if (st_q == CRFS_ST_FIN && sel_q == 4'(g))
            begin
               busy_d = 1'b0;
               if (fr_rtr_q)
               begin
                  ract_d = 1'b0;
                  done_d = 1'b0;
                  if (auto_ok)
                     arp_d = 1'b1;
                  else
                     mode_d = 4'h0;
               end
            end
            if (tx_start && tx_pick == 4'(g))
               busy_d = 1'b1;
            if (tx_mine && i_tx_done)
            begin
               busy_d = 1'b0;
               tsp_d = ts_q;
               abort_d = 1'b0;
               if (arp_q[g] || abort_q[g])
               begin
                  done_d = arp_q[g] ? 1'b1 : done_d;
                  arp_d = 1'b0;
                  mode_d = 4'h0;
                  ract_d = 1'b0;
               end
               else
               begin
                  rxdata_d = 1'b1;
                  ract_d = 1'b0;
               end
            end
            if (tx_mine && i_tx_fail)
            begin
               busy_d = 1'b0;
               if (abort_q[g])
               begin
                  abort_d = 1'b0;
                  mode_d = 4'h0;
                  ract_d = 1'b0;
                  rxdata_d = 1'b0;
                  arp_d = 1'b0;
               end
            end
         end

         always_ff @(posedge i_sys_clk)
         begin
            if (i_rst)
            begin
               mode_q[g] <= 4'h0;
               ract_q[g] <= 1'b0;
               lost_q[g] <= 1'b0;
               busy_q[g] <= 1'b0;
               done_q[g] <= 1'b0;
               rxdata_q[g] <= 1'b0;
               arp_q[g] <= 1'b0;
               abort_q[g] <= 1'b0;
               id_q[g] <= '0;
               ext_q[g] <= 1'b0;
               dlc_q[g] <= 4'h0;
               tsp_q[g] <= '0;
            end
            else
            begin
               mode_q[g] <= mode_d;
               ract_q[g] <= ract_d;
               lost_q[g] <= lost_d;
               busy_q[g] <= busy_d;
               done_q[g] <= done_d;
               rxdata_q[g] <= rxdata_d;
               arp_q[g] <= arp_d;
               abort_q[g] <= abort_d;
               id_q[g] <= id_d;
               ext_q[g] <= ext_d;
               dlc_q[g] <= dlc_d;
               tsp_q[g] <= tsp_d;
            end
         end
      end
   endgenerate

   always_comb
   begin
      st_d = st_q;
      sel_d = sel_q;
      fr_rtr_d = fr_rtr_q;
      fr_ext_d = fr_ext_q;
      fr_id_d = fr_id_q;
      fr_dlc_d = fr_dlc_q;
      tx_act_d = tx_act_q;
      tx_slot_d = tx_slot_q;
      tx_rtr_d = tx_rtr_q;
      tx_ext_d = tx_ext_q;
      tx_id_d = tx_id_q;
      tx_dlc_d = tx_dlc_q;
      ts_d = ts_q + 16'h0001;
      mask_d = mask_q;
      basic_d = basic_q;
      ien_d = ien_q;
      // Set wins over a write-one clear
      istat_d = istat_q | irq_set_w;
      unique case (st_q)
         CRFS_ST_IDLE:
         begin
            // Frames during a store are dropped
            if (i_rx_valid && (|match_w))
            begin
               sel_d = crfs_first(match_w);
               fr_rtr_d = i_rx_rtr;
               fr_ext_d = i_rx_ext;
               fr_id_d = i_rx_id;
               fr_dlc_d = i_rx_dlc;
               st_d = CRFS_ST_STORE;
            end
         end
         CRFS_ST_STORE:
            st_d = CRFS_ST_FIN;
         CRFS_ST_FIN:
            st_d = CRFS_ST_IDLE;
         default:
            st_d = CRFS_ST_IDLE;
      endcase
      if (tx_start)
      begin
         tx_act_d = 1'b1;
         tx_slot_d = tx_pick;
         tx_rtr_d = !arp_q[tx_pick];
         tx_ext_d = ext_q[tx_pick];
         tx_id_d = id_q[tx_pick];
         tx_dlc_d = dlc_q[tx_pick];
      end
      else if (tx_act_q && (i_tx_done || i_tx_fail))
         tx_act_d = 1'b0;
      if (i_reg_wr && i_reg_addr == CRFS_OFS_ID_MASK)
         mask_d = i_reg_wdata[CRFS_ID_W-1:0];
      if (i_reg_wr && i_reg_addr == CRFS_OFS_MODE)
         basic_d = i_reg_wdata[CRFS_MODE_BASIC_BIT];
      if (i_reg_wr && i_reg_addr == CRFS_OFS_IRQ_EN)
         ien_d = i_reg_wdata[CRFS_SLOTS-1:0];
      if (i_reg_wr && i_reg_addr == CRFS_OFS_IRQ_STAT)
         istat_d = (istat_q & ~i_reg_wdata[CRFS_SLOTS-1:0]) | irq_set_w;
      rdata_d = 32'h0000_0000;
      if (i_reg_rd)
      begin
         if (slot_page)
         begin
            unique case (i_reg_addr[3:0])
               CRFS_SLOT_CTRL:
                  rdata_d = {24'h00_0000, mode_q[i_reg_addr[7:4]], ract_q[i_reg_addr[7:4]],
                     lost_q[i_reg_addr[7:4]], busy_q[i_reg_addr[7:4]], done_q[i_reg_addr[7:4]]};
               CRFS_SLOT_ID:
                  rdata_d = {3'b000, id_q[i_reg_addr[7:4]]};
               CRFS_SLOT_FMT:
                  rdata_d = {23'h00_0000, ext_q[i_reg_addr[7:4]], 4'h0, dlc_q[i_reg_addr[7:4]]};
               CRFS_SLOT_TSP:
                  rdata_d = {16'h0000, tsp_q[i_reg_addr[7:4]]};
               default:
                  rdata_d = 32'h0000_0000;
            endcase
         end
         else if (i_reg_addr == CRFS_OFS_ID_MASK)
            rdata_d = {3'b000, mask_q};
         else if (i_reg_addr == CRFS_OFS_MODE)
            rdata_d = {31'h0000_0000, basic_q};
         else if (i_reg_addr == CRFS_OFS_IRQ_STAT)
            rdata_d = {16'h0000, istat_q};
         else if (i_reg_addr == CRFS_OFS_IRQ_EN)
            rdata_d = {16'h0000, ien_q};
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         st_q <= CRFS_ST_IDLE;
         sel_q <= 4'h0;
         fr_rtr_q <= 1'b0;
         fr_ext_q <= 1'b0;
         fr_id_q <= '0;
         fr_dlc_q <= 4'h0;
         tx_act_q <= 1'b0;
         tx_slot_q <= 4'h0;
         tx_rtr_q <= 1'b0;
         tx_ext_q <= 1'b0;
         tx_id_q <= '0;
         tx_dlc_q <= 4'h0;
         ts_q <= '0;
         mask_q <= CRFS_RST_MASK;
         basic_q <= 1'b0;
         istat_q <= '0;
         ien_q <= CRFS_RST_IRQ_EN;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         st_q <= st_d;
         sel_q <= sel_d;
         fr_rtr_q <= fr_rtr_d;
         fr_ext_q <= fr_ext_d;
         fr_id_q <= fr_id_d;
         fr_dlc_q <= fr_dlc_d;
         tx_act_q <= tx_act_d;
         tx_slot_q <= tx_slot_d;
         tx_rtr_q <= tx_rtr_d;
         tx_ext_q <= tx_ext_d;
         tx_id_q <= tx_id_d;
         tx_dlc_q <= tx_dlc_d;
         ts_q <= ts_d;
         mask_q <= mask_d;
         basic_q <= basic_d;
         istat_q <= istat_d;
         ien_q <= ien_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_tx_valid = tx_act_q;
   assign o_tx_slot = tx_slot_q;
   assign o_tx_rtr = tx_rtr_q;
   assign o_tx_ext = tx_ext_q;
   assign o_tx_id = tx_id_q;
   assign o_tx_dlc = tx_dlc_q;
   assign o_slot_irq_status = istat_q;
   assign o_irq_req = |(istat_q & ien_q);
endmodule
`default_nettype wire

// ---- verification/crfs_slots_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module crfs_slots_asserts
   import crfs_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Handshakes
   input wire logic i_rx_valid,
   input wire logic i_intermission,
   input wire logic o_tx_valid,
   input wire logic [3:0] o_tx_slot,
   input wire logic [CRFS_ID_W-1:0] o_tx_id,
   input wire logic [3:0] o_tx_dlc,
   input wire logic i_tx_done,
   input wire logic i_tx_fail,
   // Status
   input wire logic [CRFS_SLOTS-1:0] o_slot_irq_status,
   input wire logic o_irq_req
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   property p_tx_start;
      $rose(o_tx_valid) |-> $past(i_intermission);
   endproperty
   a_tx_start: assert property (p_tx_start)
      else $error("start without intermission");
   property p_tx_hold;
      o_tx_valid && !i_tx_done && !i_tx_fail |=> o_tx_valid;
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("send dropped early");
   property p_tx_fields;
      o_tx_valid ##1 o_tx_valid |-> $stable(o_tx_id) && $stable(o_tx_dlc) && $stable(o_tx_slot);
   endproperty
   a_tx_fields: assert property (p_tx_fields)
      else $error("fields changed mid send");
   property p_tx_end;
      o_tx_valid && (i_tx_done || i_tx_fail) |=> !o_tx_valid;
   endproperty
   a_tx_end: assert property (p_tx_end)
      else $error("send held after result");
   property p_tx_fell;
      $fell(o_tx_valid) |-> $past(i_tx_done || i_tx_fail);
   endproperty
   a_tx_fell: assert property (p_tx_fell)
      else $error("send ended without result");
   property p_tx_status;
      o_tx_valid && i_tx_done |=> o_slot_irq_status[$past(o_tx_slot)];
   endproperty
   a_tx_status: assert property (p_tx_status)
      else $error("no status after send");
   property p_irq_src;
      o_irq_req |-> o_slot_irq_status != '0;
   endproperty
   a_irq_src: assert property (p_irq_src)
      else $error("request without status");
   // Status rises only after a store or a send
   property p_stat_cause;
      (o_slot_irq_status & ~$past(o_slot_irq_status)) != '0
         |-> $past(i_rx_valid, 3) || $past(o_tx_valid && i_tx_done);
   endproperty
   a_stat_cause: assert property (p_stat_cause)
      else $error("status rose without cause");
endmodule
bind crfs_slots crfs_slots_asserts u_asserts (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
   .i_intermission(i_intermission), .o_tx_valid(o_tx_valid), .o_tx_slot(o_tx_slot),
   .o_tx_id(o_tx_id), .o_tx_dlc(o_tx_dlc), .i_tx_done(i_tx_done), .i_tx_fail(i_tx_fail),
   .o_slot_irq_status(o_slot_irq_status), .o_irq_req(o_irq_req)
);
`default_nettype wire

// ---- verification/crfs_can_node.sv ----
`timescale 1ns/100ps
`default_nettype none
module crfs_can_node
   import crfs_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Received frame
   output logic o_rx_valid,
   output logic o_rx_rtr,
   output logic o_rx_ext,
   output logic [CRFS_ID_W-1:0] o_rx_id,
   output logic [3:0] o_rx_dlc,
   // Send handshake
   input wire logic i_tx_valid,
   output logic o_intermission,
   output logic o_tx_done,
   output logic o_tx_fail
);
   // delay and fail_left are set by the bench between tests; delay also within a test
   int delay = 2;
   int fail_left = 0;
   int wait_cnt = 0;
   logic [2:0] tick = 3'h0;
   initial
   begin
      o_rx_valid = 1'b0;
      o_rx_rtr = 1'b0;
      o_rx_ext = 1'b0;
      o_rx_id = '0;
      o_rx_dlc = 4'h0;
      o_intermission = 1'b0;
      o_tx_done = 1'b0;
      o_tx_fail = 1'b0;
   end
   always @(posedge i_sys_clk)
   begin
      tick <= tick + 3'h1;
      o_intermission <= !i_rst && (tick == 3'h7);
      o_tx_done <= 1'b0;
      o_tx_fail <= 1'b0;
      wait_cnt <= 0;
      if (i_tx_valid && !o_tx_done && !o_tx_fail)
      begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt == delay)
         begin
            o_tx_fail <= (fail_left > 0);
            o_tx_done <= (fail_left == 0);
            fail_left <= (fail_left > 0) ? fail_left - 1 : 0;
         end
      end
   end
   // Stale fields are scrambled
   task automatic send(input logic rtr, input logic ext, input logic [CRFS_ID_W-1:0] id,
                       input logic [3:0] dlc);
      @(posedge i_sys_clk);
      o_rx_valid <= 1'b1;
      o_rx_rtr <= rtr;
      o_rx_ext <= ext;
      o_rx_id <= id;
      o_rx_dlc <= dlc;
      @(posedge i_sys_clk);
      o_rx_valid <= 1'b0;
      o_rx_rtr <= ~rtr;
      o_rx_ext <= ~ext;
      o_rx_id <= ~id;
      o_rx_dlc <= ~dlc;
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ---- verification/crfs_slots_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module crfs_slots_tb
   import crfs_pkg::*;
;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [CRFS_AW-1:0] i_reg_addr = '0;
   logic [31:0] i_reg_wdata = '0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [31:0] o_reg_rdata, rdv, ts_a;
   logic i_rx_valid, i_rx_rtr, i_rx_ext, i_intermission, i_tx_done, i_tx_fail;
   logic o_tx_valid, o_tx_rtr, o_tx_ext, o_irq_req;
   logic [CRFS_ID_W-1:0] i_rx_id, o_tx_id;
   logic [3:0] i_rx_dlc, o_tx_slot, o_tx_dlc;
   logic [CRFS_SLOTS-1:0] o_slot_irq_status;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int c_a;
   crfs_slots u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .i_rx_valid(i_rx_valid), .i_rx_rtr(i_rx_rtr),
      .i_rx_ext(i_rx_ext), .i_rx_id(i_rx_id), .i_rx_dlc(i_rx_dlc),
      .i_intermission(i_intermission), .o_tx_valid(o_tx_valid), .o_tx_slot(o_tx_slot),
      .o_tx_rtr(o_tx_rtr), .o_tx_ext(o_tx_ext), .o_tx_id(o_tx_id), .o_tx_dlc(o_tx_dlc),
      .i_tx_done(i_tx_done), .i_tx_fail(i_tx_fail),
      .o_slot_irq_status(o_slot_irq_status), .o_irq_req(o_irq_req));
   crfs_can_node u_node (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_rx_valid(i_rx_valid),
      .o_rx_rtr(i_rx_rtr), .o_rx_ext(i_rx_ext), .o_rx_id(i_rx_id), .o_rx_dlc(i_rx_dlc),
      .i_tx_valid(o_tx_valid), .o_intermission(i_intermission), .o_tx_done(i_tx_done),
      .o_tx_fail(i_tx_fail));
   initial
   begin
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) cyc <= cyc + 1;
   function automatic logic [11:0] sa(input logic [3:0] n, input logic [3:0] r);
      return {CRFS_SLOT_PAGE, n, r};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1;
      d = o_reg_rdata;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
      rd(a, rdv);
      cmp(rdv & m, exp, "register");
   endtask
   task automatic wait_tx(input logic lvl);
      int n = 0;
      while (o_tx_valid !== lvl && n < 300)
      begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      cmp(32'(o_tx_valid), 32'(lvl), "handshake");
   endtask
   // Stop, check busy low, then set fields
   task automatic setup(input logic [3:0] n, input logic [7:0] cmd, input logic [28:0] id,
                        input logic ext);
      wr(sa(n, CRFS_SLOT_CTRL), 32'h0000_0000);
      chk(sa(n, CRFS_SLOT_CTRL), 32'h0000_0000, 32'h0000_0002);
      wr(sa(n, CRFS_SLOT_ID), 32'(id));
      wr(sa(n, CRFS_SLOT_FMT), 32'(ext) << CRFS_FMT_EXT_BIT);
      wr(sa(n, CRFS_SLOT_CTRL), 32'(cmd));
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      fail_count++;
      $display("unexpected at %0t: watchdog", $time);
      results();
   end
   initial
   begin
      repeat (4) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      chk(CRFS_OFS_ID_MASK, 32'h1FFF_FFFF, 32'hFFFF_FFFF);
      chk(CRFS_OFS_IRQ_EN, 32'h0000_0000, 32'hFFFF_FFFF);
      wr(12'hFF0, 32'hFFFF_FFFF);
      chk(12'hFF0, 32'h0000_0000, 32'hFFFF_FFFF);
      $display("test reset done");
      wr(CRFS_OFS_IRQ_EN, 32'h0000_0008);
      setup(4'd3, CRFS_CMD_REM_NOAUTO, 29'h0000_0123, 1'b0);
      setup(4'd5, CRFS_CMD_REM_NOAUTO, 29'h0000_0123, 1'b0);
      chk(sa(4'd3, CRFS_SLOT_CTRL), 32'h0000_0078, 32'h0000_00FF);
      u_node.send(1'b1, 1'b0, 29'h0000_0555, 4'd2);
      u_node.send(1'b0, 1'b0, 29'h0000_0123, 4'd2);
      chk(CRFS_OFS_IRQ_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
      c_a = cyc;
      u_node.send(1'b1, 1'b0, 29'h0000_0123, 4'd5);
      cmp(32'(o_irq_req), 32'h0000_0001, "request");
      chk(CRFS_OFS_IRQ_STAT, 32'h0000_0008, 32'hFFFF_FFFF);
      cmp(32'(o_slot_irq_status), 32'h0000_0008, "status");
      chk(sa(4'd3, CRFS_SLOT_CTRL), 32'h0000_0000, 32'h0000_00FF);
      chk(sa(4'd3, CRFS_SLOT_FMT), 32'h0000_0005, 32'h0000_01FF);
      chk(sa(4'd3, CRFS_SLOT_ID), 32'h0000_0123, 32'h0000_07FF);
      chk(sa(4'd5, CRFS_SLOT_CTRL), 32'h0000_0078, 32'h0000_00FF);
      rd(sa(4'd3, CRFS_SLOT_TSP), ts_a);
      wr(CRFS_OFS_IRQ_STAT, 32'h0000_0008);
      cmp(32'(o_irq_req), 32'h0000_0000, "request");
      c_a = cyc - c_a;
      u_node.send(1'b1, 1'b0, 29'h0000_0123, 4'd1);
      cmp(32'(o_irq_req), 32'h0000_0000, "request");
      chk(CRFS_OFS_IRQ_STAT, 32'h0000_0020, 32'hFFFF_FFFF);
      rd(sa(4'd5, CRFS_SLOT_TSP), rdv);
      cmp(32'(16'(rdv - ts_a)), 32'(16'(c_a)), "time stamp");
      $display("test remote receive done");
      wr(CRFS_OFS_IRQ_STAT, 32'h0000_FFFF);
      wr(CRFS_OFS_ID_MASK, 32'h1FFF_FFF0);
      u_node.fail_left = 1;
      u_node.delay = 8;
      setup(4'd1, CRFS_CMD_REM_AUTO, 29'h1ABC_DEF0, 1'b1);
      u_node.send(1'b1, 1'b1, 29'h1ABC_DEF3, 4'd3);
      wait_tx(1'b1);
      cmp(32'({o_tx_slot, o_tx_rtr, o_tx_ext, o_tx_dlc}), 32'h0000_0053, "reply");
      cmp(32'(o_tx_id), 32'h1ABC_DEF3, "reply id");
      chk(sa(4'd1, CRFS_SLOT_CTRL), 32'h0000_0002, 32'h0000_0002);
      wait_tx(1'b0);
      wait_tx(1'b1);
      wait_tx(1'b0);
      chk(sa(4'd1, CRFS_SLOT_CTRL), 32'h0000_0001, 32'h0000_00FF);
      chk(CRFS_OFS_IRQ_STAT, 32'h0000_0002, 32'hFFFF_FFFF);
      $display("test auto reply done");
      wr(CRFS_OFS_MODE, 32'h0000_0001);
      setup(4'd14, CRFS_CMD_REM_AUTO, 29'h0000_0200, 1'b0);
      u_node.send(1'b1, 1'b0, 29'h0000_0200, 4'd1);
      c_a = 0;
      repeat (40)
      begin
         @(posedge i_sys_clk);
         #1;
         if (o_tx_valid !== 1'b0) c_a++;
      end
      cmp(32'(c_a), 32'h0000_0000, "basic send");
      chk(CRFS_OFS_IRQ_STAT, 32'h0000_4000, 32'h0000_4000);
      wr(sa(4'd14, CRFS_SLOT_CTRL), 32'h0000_0000);
      wr(CRFS_OFS_MODE, 32'h0000_0000);
      $display("test basic mode done");
      wr(CRFS_OFS_ID_MASK, 32'h1FFF_FFFF);
      u_node.delay = 6;
      setup(4'd0, CRFS_CMD_RETX, 29'h0000_0321, 1'b0);
      wait_tx(1'b1);
      cmp(32'({o_tx_slot, o_tx_rtr, o_tx_ext}), 32'h0000_0002, "remote send");
      chk(sa(4'd0, CRFS_SLOT_CTRL), 32'h0000_000A, 32'h0000_000A);
      wait_tx(1'b0);
      chk(sa(4'd0, CRFS_SLOT_CTRL), 32'h0000_0000, 32'h0000_000F);
      u_node.send(1'b0, 1'b0, 29'h0000_0321, 4'd8);
      chk(sa(4'd0, CRFS_SLOT_CTRL), 32'h0000_0001, 32'h0000_000F);
      wr(sa(4'd0, CRFS_SLOT_CTRL), 32'(CRFS_CMD_RXDATA));
      chk(sa(4'd0, CRFS_SLOT_FMT), 32'h0000_0008, 32'h0000_01FF);
      chk(sa(4'd0, CRFS_SLOT_CTRL), 32'h0000_0000, 32'h0000_0001);
      u_node.send(1'b0, 1'b0, 29'h0000_0321, 4'd2);
      u_node.send(1'b0, 1'b0, 29'h0000_0321, 4'd2);
      chk(sa(4'd0, CRFS_SLOT_CTRL), 32'h0000_0005, 32'h0000_0007);
      u_node.delay = 20;
      wr(sa(4'd0, CRFS_SLOT_CTRL), 32'(CRFS_CMD_RETX));
      chk(sa(4'd0, CRFS_SLOT_CTRL), 32'h0000_0008, 32'h0000_0009);
      wait_tx(1'b1);
      cmp(32'(o_tx_rtr), 32'h0000_0001, "remote send");
      wr(sa(4'd0, CRFS_SLOT_CTRL), 32'(CRFS_CMD_CANCEL));
      c_a = 0;
      do
      begin
         rd(sa(4'd0, CRFS_SLOT_CTRL), rdv);
         c_a++;
      end
      while (rdv[CRFS_CB_RACT] !== 1'b0 && c_a < 40);
      cmp(rdv & 32'h0000_000A, 32'h0000_0000, "abort");
      cmp(32'(o_tx_valid), 32'h0000_0000, "abort");
      setup(4'd3, CRFS_CMD_REM_NOAUTO, 29'h0000_0123, 1'b0);
      wr(sa(4'd3, CRFS_SLOT_CTRL), 32'(CRFS_CMD_STOP));
      chk(sa(4'd3, CRFS_SLOT_CTRL), 32'h0000_0000, 32'h0000_000F);
      wr(CRFS_OFS_IRQ_STAT, 32'h0000_FFFF);
      u_node.send(1'b1, 1'b0, 29'h0000_0123, 4'd1);
      u_node.send(1'b0, 1'b0, 29'h0000_0321, 4'd1);
      chk(CRFS_OFS_IRQ_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
      $display("test remote send done");
      results();
   end
endmodule
`default_nettype wire
